// *** hw/sesr_core.sv ***
// serial link error checking and status reporting of the sensor device
// assumes the pins arrive asynchronous to core_clk and the serial clock is far
// slower than core_clk (at least eight core cycles per serial clock phase)
//
// Summary of operation
// - detail status of each response is captured when select rose ending the last frame
// - compute or temperature error flags give detail code 00
// - user or factory memory error flags give detail code 01
// - test mode, supply error or reset error give detail code 10
// - serial clock high when select asserts is a serial error
// - rising clock edge count other than 16 in a frame is a serial error
// - serial clock high when select deasserts is a serial error
// - incoming command checksum failure is a serial error
// - after init lock, writes other than to lock control register are serial errors
// - serial error answers with detail code 11 in the error response
// - every output bit driven ahead of a rising clock edge is compared with the intended bit
// - any output mismatch sets the output mismatch status flag
// - sensor request in a mismatching frame is dropped, error response follows
// - write in a mismatching frame still happens, error response follows
// - read in a mismatching frame is not done, error response follows
// - messages carry an 8 bit checksum, polynomial 0x2f, msb first
// - basic status 11 marks internal error, detail field names the source
`timescale 1ns/1ps
`default_nettype none

module sesr_core
	import sesr_pkg::*;
(
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        rstn,
	// serial pins
	input  wire logic        spi_sclk,
	input  wire logic        spi_ss_n,
	input  wire logic        spi_mosi,
	input  wire logic        spi_miso_fb,
	output logic             spi_miso,
	output logic             spi_miso_oe,
	// device condition
	input  wire sesr_flags_t dev_flags,
	input  wire logic [7:0]  supply_status,
	input  wire logic [7:0]  temp_value,
	input  wire logic [19:0] sensor_data,
	input  wire logic        init_done_lock,
	input  wire logic [7:0]  ext_rdata,
	// register requests
	output logic             wr_req,
	output logic [5:0]       wr_addr,
	output logic [7:0]       wr_data,
	output logic             ext_rd_req,
	output logic [5:0]       rd_addr,
	output logic             sensor_req,
	output logic             verify_flag
);

	// ****************************************************************
	// functions
	// ****************************************************************
	// one checksum step, message bit rotates into the lsb, msb leaves first
	function automatic logic [7:0] crc_step(input logic [7:0] c, input logic b);
		logic fb;
		fb = c[7];
		return {c[6:0], b} ^ (fb ? SESR_CRC_POLY : 8'h00);
	endfunction

	// checksum over the upper 24 bits of a response
	function automatic logic [7:0] crc_word(input logic [23:0] w);
		logic [7:0] c;
		c = SESR_CRC_SEED;
		for (int i = 23; i >= 0; i--) begin
			c = crc_step(c, w[i]);
		end
		for (int i = 0; i < 8; i++) begin
			c = crc_step(c, 1'b0);
		end
		return c;
	endfunction

	// ****************************************************************
	// pin synchronisers
	// ****************************************************************
	logic [3:0] sync1_ff;
	logic [3:0] sync2_ff;
	logic       sclk_prev_ff;
	logic       ss_prev_ff;
	wire  logic sclk_s   = sync2_ff[0];
	wire  logic ss_n_s   = sync2_ff[1];
	wire  logic mosi_s   = sync2_ff[2];
	wire  logic fb_s     = sync2_ff[3];
	wire  logic sel      = ~ss_n_s;
	wire  logic ss_fall  = ss_prev_ff & ~ss_n_s;
	wire  logic ss_rise  = ~ss_prev_ff & ss_n_s;
	wire  logic clk_rise = sel & ~sclk_prev_ff & sclk_s;
	wire  logic clk_fall = sel & sclk_prev_ff & ~sclk_s;

	// two flops per pin, reset to idle levels so no false edge follows reset
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			sync1_ff     <= 4'h2;
			sync2_ff     <= 4'h2;
			sclk_prev_ff <= 1'b0;
			ss_prev_ff   <= 1'b1;
		end else begin
			sync1_ff     <= {spi_miso_fb, spi_mosi, spi_ss_n, spi_sclk};
			sync2_ff     <= sync1_ff;
			sclk_prev_ff <= sync2_ff[0];
			ss_prev_ff   <= sync2_ff[1];
		end
	end

	// ****************************************************************
	// frame capture
	// ****************************************************************
	logic [5:0]  cnt_ff;
	logic [31:0] rx_ff;
	logic [7:0]  crc_rx_ff;
	logic        start_err_ff;
	logic        mism_ff;
	logic [31:0] tx_ff;
	logic        miso_ff;
	sesr_resp_t  resp_ff;

	wire logic [5:0] cnt_inc = (cnt_ff == SESR_EDGE_MAX) ? cnt_ff : 6'(cnt_ff + 6'h01);
	wire logic       bit_bad = clk_rise & (fb_s != miso_ff);

	// counter, receive shift, checksum and mismatch capture per frame
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			cnt_ff       <= 6'h00;
			rx_ff        <= 32'h0000_0000;
			crc_rx_ff    <= SESR_CRC_SEED;
			start_err_ff <= 1'b0;
			mism_ff      <= 1'b0;
		end else if (ss_fall) begin
			cnt_ff       <= 6'h00;
			mism_ff      <= 1'b0;
			crc_rx_ff    <= SESR_CRC_SEED;
			start_err_ff <= sclk_s;
		end else if (clk_rise) begin
			cnt_ff    <= cnt_inc;
			rx_ff     <= {rx_ff[30:0], mosi_s};
			crc_rx_ff <= crc_step(crc_rx_ff, mosi_s);
			mism_ff   <= mism_ff | bit_bad;
		end
	end

	// output shift: first bit out at select, next bit after each falling edge
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			tx_ff   <= 32'h0000_0000;
			miso_ff <= 1'b0;
		end else if (ss_fall) begin
			tx_ff   <= {resp_ff[30:0], 1'b0};
			miso_ff <= resp_ff[31];
		end else if (clk_fall) begin
			tx_ff   <= {tx_ff[30:0], 1'b0};
			miso_ff <= tx_ff[31];
		end
	end

	assign spi_miso    = miso_ff;
	assign spi_miso_oe = sel;

	// ****************************************************************
	// frame evaluation at select release
	// ****************************************************************
	sesr_cmd_msg_t cmd;
	sesr_cmd_t     kind;
	assign cmd  = sesr_cmd_msg_t'(rx_ff);
	assign kind = sesr_cmd_t'(cmd.kind);

	wire logic err_start = start_err_ff;
	wire logic err_count = (cnt_ff != SESR_FRAME_EDGES);
	wire logic err_end   = sclk_s;
	wire logic err_crc   = (crc_rx_ff != 8'h00);
	wire logic err_lock  = init_done_lock & (kind == SESR_CMD_WRITE)
	                     & (cmd.addr != SESR_LOCK_CTRL_ADDR);
	wire logic frame_err = err_start | err_count | err_end | err_crc | err_lock;
	wire logic valid     = ~frame_err;
	wire logic do_write  = ss_rise & valid & (kind == SESR_CMD_WRITE);
	wire logic do_read   = ss_rise & valid & ~mism_ff & (kind == SESR_CMD_READ);
	wire logic do_sense  = ss_rise & valid & ~mism_ff & (kind == SESR_CMD_SENSOR);
	wire logic local_rd  = (cmd.addr[5:4] == 2'b00);

	// ****************************************************************
	// status registers
	// ****************************************************************
	logic [7:0] roll_ff;
	logic       verify_ff;
	logic       comm_ff;

	wire logic supply_err  = |supply_status;
	wire logic memtemp_err = dev_flags.uotp_err | dev_flags.urw_err | dev_flags.fotp_err
	                       | dev_flags.temp_err;
	logic [7:0] summary_reg;
	logic [7:0] memtemp_reg;
	logic [7:0] verify_reg;
	always_comb begin
		summary_reg                   = 8'h00;
		summary_reg[SESR_SUM_DSP]     = dev_flags.compute_error_flag;
		summary_reg[SESR_SUM_COMM]    = comm_ff;
		summary_reg[SESR_SUM_MEMTEMP] = memtemp_err;
		summary_reg[SESR_SUM_SUPPLY]  = supply_err;
		summary_reg[SESR_SUM_TEST]    = dev_flags.test_active_flag;
		summary_reg[SESR_SUM_RESET]   = dev_flags.reset_error_flag;
		summary_reg[SESR_SUM_INIT]    = dev_flags.initializing_flag;
		memtemp_reg                   = 8'h00;
		memtemp_reg[SESR_MT_FOTP]     = dev_flags.fotp_err;
		memtemp_reg[SESR_MT_UOTP]     = dev_flags.uotp_err;
		memtemp_reg[SESR_MT_URW]      = dev_flags.urw_err;
		memtemp_reg[SESR_MT_TEMP]     = dev_flags.temp_err;
		verify_reg                    = 8'h00;
		verify_reg[SESR_VER_MISM]     = verify_ff;
	end

	// read mux for offsets 00h to 0Fh; reserved offsets read zero
	logic [7:0] local_rdata;
	always_comb begin
		case (cmd.addr[3:0])
			SESR_REG_ROLL:    local_rdata = roll_ff;
			SESR_REG_SUMMARY: local_rdata = summary_reg;
			SESR_REG_SUPPLY:  local_rdata = supply_status;
			SESR_REG_MEMTEMP: local_rdata = memtemp_reg;
			SESR_REG_VERIFY:  local_rdata = verify_reg;
			SESR_REG_TEMP:    local_rdata = temp_value;
			default:          local_rdata = 8'h00;
		endcase
	end

	// mismatch flag is sticky, cleared by a read of its register; a new set wins
	wire logic verify_clr = do_read & local_rd & (cmd.addr[3:0] == SESR_REG_VERIFY);
	wire logic nxt_verify = bit_bad | (verify_ff & ~verify_clr);
	wire logic nxt_comm   = (ss_rise & frame_err) | (comm_ff & ~(do_read & local_rd
	                      & (cmd.addr[3:0] == SESR_REG_SUMMARY)));
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			roll_ff   <= SESR_ROLL_RESET;
			verify_ff <= 1'b0;
			comm_ff   <= 1'b0;
		end else begin
			roll_ff   <= do_sense ? 8'(roll_ff + 8'h01) : roll_ff;
			verify_ff <= nxt_verify;
			comm_ff   <= nxt_comm;
		end
	end
	assign verify_flag = verify_ff;

	// ****************************************************************
	// next response
	// ****************************************************************
	// serial faults outrank everything, then supply, then memory, then compute
	wire logic src_serial  = frame_err | mism_ff;
	wire logic src_supply  = dev_flags.test_active_flag | supply_err
	                       | dev_flags.reset_error_flag;
	wire logic src_memory  = dev_flags.uotp_err | dev_flags.urw_err
	                       | dev_flags.fotp_err;
	wire logic src_compute = dev_flags.compute_error_flag | dev_flags.temp_err;
	wire logic any_err     = src_serial | src_supply | src_memory | src_compute;
	wire logic [1:0] nxt_detail = src_serial ? SESR_SF_SERIAL :
	                              src_supply ? SESR_SF_SUPPLY :
	                              src_memory ? SESR_SF_MEMORY : SESR_SF_COMPUTE;
	wire logic [1:0] nxt_basic  = any_err ? SESR_ST_ERROR :
	                              dev_flags.self_test ? SESR_ST_SELF :
	                              init_done_lock ? SESR_ST_NORMAL : SESR_ST_INIT;
	wire logic [7:0] rd_value   = local_rd ? local_rdata : ext_rdata;
	wire logic [19:0] nxt_payload = src_serial ? 20'h0_0000 :
	                               do_sense ? sensor_data :
	                               do_read ? {12'h000, rd_value} : 20'h0_0000;
	wire logic [23:0] nxt_head  = {nxt_basic, nxt_detail, nxt_payload};

	// response is frozen between frames so it reflects the select release
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			resp_ff <= {24'h00_0000, crc_word(24'h00_0000)};
		end else if (ss_rise) begin
			resp_ff <= {nxt_head, crc_word(nxt_head)};
		end
	end

	// ****************************************************************
	// request strobes
	// ****************************************************************
	logic       wr_ff;
	logic       ext_rd_ff;
	logic       sense_ff;
	logic [5:0] wa_ff;
	logic [7:0] wd_ff;
	logic [5:0] ra_ff;
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			wr_ff     <= 1'b0;
			ext_rd_ff <= 1'b0;
			sense_ff  <= 1'b0;
			wa_ff     <= 6'h00;
			wd_ff     <= 8'h00;
			ra_ff     <= 6'h00;
		end else begin
			wr_ff     <= do_write;
			ext_rd_ff <= do_read & ~local_rd;
			sense_ff  <= do_sense;
			wa_ff     <= do_write ? cmd.addr : wa_ff;
			wd_ff     <= do_write ? cmd.wdata : wd_ff;
			ra_ff     <= do_read ? cmd.addr : ra_ff;
		end
	end
	assign wr_req     = wr_ff;
	assign wr_addr    = wa_ff;
	assign wr_data    = wd_ff;
	assign ext_rd_req = ext_rd_ff;
	assign rd_addr    = ra_ff;
	assign sensor_req = sense_ff;

	// ****************************************************************
	// assertions
	// ****************************************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);

	AST_FRAME_ERR_RESP: assert property (
		ss_rise && frame_err |=> resp_ff.detail_status_field == 2'h3
		&& resp_ff.basic_status_field == 2'h3)
		else $error("serial error not reported as code 11");
	AST_EDGE_COUNT: assert property (
		ss_rise && cnt_ff != 6'h10 |=> !wr_req && !sensor_req && !ext_rd_req
		&& resp_ff.detail_status_field == 2'h3)
		else $error("wrong edge count not flagged");
	AST_START_HIGH: assert property (
		ss_fall && sclk_s |=> start_err_ff throughout (sel [*3]))
		else $error("clock high at select not caught");
	AST_END_HIGH: assert property (
		ss_rise && sclk_s |=> resp_ff.detail_status_field == 2'h3)
		else $error("clock high at release not caught");
	AST_CLEAR: assert property (
		ss_fall |=> cnt_ff == 6'h00 && !mism_ff)
		else $error("frame capture not cleared at select");
	AST_MISMATCH: assert property (
		clk_rise && fb_s != miso_ff |=> verify_flag && mism_ff)
		else $error("output mismatch not flagged");
	AST_MISM_NO_ACT: assert property (
		ss_rise && mism_ff |=> !sensor_req && !ext_rd_req
		&& resp_ff.detail_status_field == 2'h3)
		else $error("request acted on despite mismatch");
	AST_MISM_WRITE: assert property (
		ss_rise && valid && mism_ff && kind == SESR_CMD_WRITE |=> wr_req
		&& wr_addr == $past(cmd.addr))
		else $error("write dropped on mismatch");
	AST_LOCK: assert property (
		ss_rise && init_done_lock && kind == SESR_CMD_WRITE
		&& cmd.addr != 6'h10 |=> !wr_req)
		else $error("locked write performed");
	AST_CRC_BAD: assert property (
		ss_rise && crc_rx_ff != 8'h00 |=> !wr_req && !sensor_req && !ext_rd_req)
		else $error("bad checksum accepted");
	AST_TEST_CODE: assert property (
		ss_rise && !src_serial && dev_flags.test_active_flag
		|=> resp_ff.detail_status_field == 2'h2)
		else $error("test mode code wrong");
	AST_RESP_HOLD: assert property (
		!ss_rise |=> $stable(resp_ff) && resp_ff.crc == crc_word(resp_ff[31:8]))
		else $error("response changed between frames");

	COV_GOOD_WRITE: cover property (ss_rise && valid && kind == SESR_CMD_WRITE);
	COV_SENSOR:     cover property (ss_rise && valid && !mism_ff && kind == SESR_CMD_SENSOR);
	COV_MISMATCH:   cover property (ss_rise && mism_ff);
	COV_BAD_COUNT:  cover property (ss_rise && err_count);

endmodule

`default_nettype wire

// *** hw/sesr_pkg.sv ***
// package for the serial error and status reporting block
// assumes one core clock; the serial link pins are sampled, not used as clocks
package sesr_pkg;

	// ****************************************************************
	// frame and checksum constants
	// ****************************************************************
	localparam logic [5:0] SESR_FRAME_EDGES = 6'h10;   // rising edges per frame
	localparam logic [5:0] SESR_EDGE_MAX    = 6'h3f;   // counter saturates here
	localparam logic [7:0] SESR_CRC_POLY    = 8'h2f;   // x^8+x^5+x^3+x^2+x+1
	localparam logic [7:0] SESR_CRC_SEED    = 8'hff;
	localparam int         SESR_RESP_BITS   = 32;

	// ****************************************************************
	// register offsets and field positions
	// ****************************************************************
	localparam logic [5:0] SESR_LOCK_CTRL_ADDR = 6'h10;  // lock and reset control
	localparam logic [3:0] SESR_REG_ROLL    = 4'h0;
	localparam logic [3:0] SESR_REG_SUMMARY = 4'h1;
	localparam logic [3:0] SESR_REG_SUPPLY  = 4'h2;
	localparam logic [3:0] SESR_REG_MEMTEMP = 4'h3;
	localparam logic [3:0] SESR_REG_VERIFY  = 4'h4;
	localparam logic [3:0] SESR_REG_TEMP    = 4'he;
	localparam int SESR_SUM_DSP     = 7;
	localparam int SESR_SUM_COMM    = 5;
	localparam int SESR_SUM_MEMTEMP = 4;
	localparam int SESR_SUM_SUPPLY  = 3;
	localparam int SESR_SUM_TEST    = 2;
	localparam int SESR_SUM_RESET   = 1;
	localparam int SESR_SUM_INIT    = 0;
	localparam int SESR_MT_FOTP     = 7;
	localparam int SESR_MT_UOTP     = 6;
	localparam int SESR_MT_URW      = 5;
	localparam int SESR_MT_TEMP     = 2;
	localparam int SESR_VER_MISM    = 7;
	localparam logic [7:0] SESR_ROLL_RESET = 8'h00;

	// ****************************************************************
	// status codes
	// ****************************************************************
	localparam logic [1:0] SESR_ST_INIT   = 2'h0;
	localparam logic [1:0] SESR_ST_NORMAL = 2'h1;
	localparam logic [1:0] SESR_ST_SELF   = 2'h2;
	localparam logic [1:0] SESR_ST_ERROR  = 2'h3;
	localparam logic [1:0] SESR_SF_COMPUTE = 2'h0;
	localparam logic [1:0] SESR_SF_MEMORY  = 2'h1;
	localparam logic [1:0] SESR_SF_SUPPLY  = 2'h2;
	localparam logic [1:0] SESR_SF_SERIAL  = 2'h3;

	// ****************************************************************
	// types
	// ****************************************************************
	typedef enum logic [1:0] {SESR_CMD_SENSOR, SESR_CMD_READ, SESR_CMD_WRITE, SESR_CMD_RSVD} sesr_cmd_t;

	typedef struct packed {
		logic [1:0] kind;
		logic [5:0] addr;
		logic [7:0] wdata;
		logic [7:0] spare;
		logic [7:0] crc;
	} sesr_cmd_msg_t;

	typedef struct packed {
		logic [1:0]  basic_status_field;
		logic [1:0]  detail_status_field;
		logic [19:0] payload;
		logic [7:0]  crc;
	} sesr_resp_t;

	typedef struct packed {
		logic compute_error_flag;
		logic temp_err;
		logic uotp_err;
		logic urw_err;
		logic fotp_err;
		logic test_active_flag;
		logic reset_error_flag;
		logic initializing_flag;
		logic self_test;
	} sesr_flags_t;

endpackage

// *** dv/sesr_host.sv ***
// host controller model for the serial error and status block
// assumes core_clk at 100 MHz; serial clock period 16 core cycles, idle low
`timescale 1ns/1ps
`default_nettype none

module sesr_host
	import sesr_pkg::*;
(
	// clock
	input  wire logic core_clk,
	// serial pins
	output logic      spi_sclk,
	output logic      spi_ss_n,
	output logic      spi_mosi,
	output logic      spi_miso_fb,
	input  wire logic spi_miso,
	input  wire logic spi_miso_oe
);
	// ********
	// pin levels
	// ********
	logic flip = 1'b0;
	logic last = 1'b0;
	initial begin
		spi_sclk = 1'b0;
		spi_ss_n = 1'b1;
		spi_mosi = 1'b0;
	end
	// a released pin floats, so the readback shows the inverse of its last level
	assign spi_miso_fb = spi_miso_oe ? (spi_miso ^ flip) : ~last;
	always @(posedge core_clk) if (spi_miso_oe) last <= spi_miso;

	// checksum of one byte then eight zeros, seed all ones, msb first
	function automatic logic [7:0] crc8(input logic [7:0] d);
		logic [7:0]  c;
		logic [15:0] w;
		c = SESR_CRC_SEED;
		w = {d, 8'h00};
		for (int i = 15; i >= 0; i--) begin
			c = {c[6:0], w[i]} ^ (c[7] ? SESR_CRC_POLY : 8'h00);
		end
		return c;
	endfunction

	// mode: 0 clean, 1 clock high at select, 2 clock high at release,
	// 3 fifteen edges, 4 seventeen edges, 5 bad checksum, 6 readback fault
	task automatic xfer(input logic [7:0] d, input int mode, output logic [15:0] rsp);
		logic [15:0] w;
		int          n;
		w = {d, crc8(d)};
		w[0] = w[0] ^ (mode == 5);
		n = (mode == 3) ? 15 : (mode == 4) ? 17 : 16;
		rsp = 16'h0000;
		spi_sclk <= (mode == 1);
		repeat (8) @(posedge core_clk);
		spi_ss_n <= 1'b0;
		repeat (8) @(posedge core_clk);
		spi_sclk <= 1'b0;
		for (int i = 0; i < n; i++) begin
			spi_mosi <= (i < 16) ? w[15 - i] : 1'b0;
			flip <= (mode == 6) && (i == 5);
			repeat (8) @(posedge core_clk);
			if (i < 16) rsp[15 - i] = spi_miso;
			spi_sclk <= 1'b1;
			repeat (8) @(posedge core_clk);
			if (!(mode == 2 && i == n - 1)) spi_sclk <= 1'b0;
		end
		repeat (8) @(posedge core_clk);
		spi_ss_n <= 1'b1;
		spi_mosi <= ~spi_mosi;
		flip <= 1'b0;
		// leave room for the request pulses that follow the release
		repeat (8) @(posedge core_clk);
	endtask
endmodule

`default_nettype wire

// *** dv/tb_top.sv ***
// self-checking bench for the serial error and status block
// assumes sesr_host on the serial pins; response status, pulses and flag checked
`timescale 1ns/1ps
`default_nettype none

module tb_top
	import sesr_pkg::*;
;
	// ********
	// signals
	// ********
	logic        core_clk = 1'b0;
	logic        rstn = 1'b0;
	logic        sclk, ss_n, mosi, miso, miso_oe, miso_fb;
	sesr_flags_t dev_flags = '0;
	logic [7:0]  supply_status = 8'h00, temp_value = 8'h00, ext_rdata = 8'h00;
	logic [19:0] sensor_data = 20'h0_0000;
	logic        init_done_lock = 1'b0;
	logic        wr_req, ext_rd_req, sensor_req, verify_flag, clr = 1'b0;
	logic [5:0]  wr_addr, rd_addr;
	logic [7:0]  wr_data;
	logic [2:0]  seen;
	logic [31:0] seed = 32'h5dc9_c442;
	int          err_total = 0, samples_checked = 0;

	always #5 core_clk = ~core_clk;

	sesr_host host (.core_clk(core_clk), .spi_sclk(sclk), .spi_ss_n(ss_n), .spi_mosi(mosi),
		.spi_miso_fb(miso_fb), .spi_miso(miso), .spi_miso_oe(miso_oe));

	sesr_core dut (.core_clk(core_clk), .rstn(rstn), .spi_sclk(sclk), .spi_ss_n(ss_n),
		.spi_mosi(mosi), .spi_miso_fb(miso_fb), .spi_miso(miso), .spi_miso_oe(miso_oe),
		.dev_flags(dev_flags), .supply_status(supply_status), .temp_value(temp_value),
		.sensor_data(sensor_data), .init_done_lock(init_done_lock), .ext_rdata(ext_rdata),
		.wr_req(wr_req), .wr_addr(wr_addr), .wr_data(wr_data), .ext_rd_req(ext_rd_req),
		.rd_addr(rd_addr), .sensor_req(sensor_req), .verify_flag(verify_flag));

	// pulses are one cycle wide, so gather them per frame
	always @(posedge core_clk) seen <= clr ? 3'b000 : (seen | {wr_req, ext_rd_req, sensor_req});

	// ********
	// expectations
	// ********
	function logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	function automatic logic bad_wr(input logic [7:0] c, input logic lk);
		return (c[7:6] == 2'b10) && lk && (c[5:0] != SESR_LOCK_CTRL_ADDR);
	endfunction

	// serial fault first, then supply, memory, compute sources
	function automatic logic [3:0] exp_st(input sesr_flags_t f, input logic [7:0] s,
		input logic lk, input logic se);
		logic [1:0] sf;
		logic       src;
		src = 1'b1;
		if (se) sf = SESR_SF_SERIAL;
		else if (f.test_active_flag | f.reset_error_flag | (|s)) sf = SESR_SF_SUPPLY;
		else if (f.uotp_err | f.urw_err | f.fotp_err) sf = SESR_SF_MEMORY;
		else begin
			sf = SESR_SF_COMPUTE;
			src = f.compute_error_flag | f.temp_err;
		end
		if (src) return {SESR_ST_ERROR, sf};
		if (f.self_test) return {SESR_ST_SELF, sf};
		return {lk ? SESR_ST_NORMAL : SESR_ST_INIT, sf};
	endfunction

	// pulses {write, read, sensor}; a readback fault keeps only the write, reserved none
	function automatic logic [2:0] exp_ev(input logic [7:0] c, input int m, input logic lk);
		if ((m != 0 && m != 6) || bad_wr(c, lk) || (c[7:6] == 2'b11)) return 3'b000;
		if (c[7:6] == 2'b10) return 3'b100;
		if (c[7:6] == 2'b01) return {1'b0, (m != 6) && (c[5:4] != 2'b00), 1'b0};
		return {2'b00, m != 6};
	endfunction

	// ********
	// tasks
	// ********
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		samples_checked++;
		if (g !== e) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic setc(input logic [8:0] f, input logic [7:0] s, input logic lk);
		dev_flags <= sesr_flags_t'(f);
		supply_status <= s;
		init_done_lock <= lk;
		@(posedge core_clk);
	endtask

	// prime the command byte, run the judged frame, read its status next frame
	task automatic do_cmd(input logic [7:0] c, input int m, input logic ck);
		logic [15:0] r;
		logic [2:0]  ev;
		logic [3:0]  es;
		ev = exp_ev(c, m, init_done_lock);
		es = exp_st(dev_flags, supply_status, init_done_lock, (m != 0) || bad_wr(c, init_done_lock));
		host.xfer(c, 0, r);
		clr <= 1'b1;
		@(posedge core_clk);
		clr <= 1'b0;
		host.xfer(8'h00, m, r);
		chk("pulses", 16'(ev), 16'(seen));
		if (ev[2]) chk("write", {2'b00, c[5:0], host.crc8(c)}, {2'b00, wr_addr, wr_data});
		if (ev[1]) chk("rd_addr", 16'(c[5:0]), 16'(rd_addr));
		host.xfer(8'h00, 0, r);
		if (ck) chk("response", {es, ev[0] ? sensor_data[19:8] : 12'h000}, r);
	endtask

	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// ********
	// sequence
	// ********
	initial begin
		logic [7:0]  mc [3];
		logic [31:0] r;
		int          k;
		mc = '{8'h00, 8'h85, 8'h52};
		repeat (12) @(posedge core_clk);
		rstn <= 1'b1;
		repeat (4) @(posedge core_clk);
		do_cmd(8'h00, 0, 1);
		for (k = 0; k < 10; k++) begin
			setc(9'h001 << k, (k == 9) ? 8'h01 : 8'h00, 1'b0);
			do_cmd(8'h00, 0, 1);
		end
		for (k = 0; k < 12; k++) begin
			r = rnd();
			sensor_data <= r[19:0];
			temp_value <= r[27:20];
			ext_rdata <= r[31:24];
			setc(r[8:0] & r[17:9] & r[26:18], r[28] ? r[7:0] : 8'h00, r[29]);
			do_cmd({r[31] ? 2'b10 : {1'b0, r[30]}, r[13:8]}, 0, 1);
		end
		setc(9'h000, 8'h00, 1'b0);
		for (k = 1; k < 6; k++) begin
			do_cmd(8'h00, k, 1);
		end
		for (k = 0; k < 3; k++) begin
			do_cmd(mc[k], 6, 1);
			chk("verify_flag", 16'h0001, 16'(verify_flag));
			do_cmd(8'h44, 0, 0);
			chk("verify_flag", 16'h0000, 16'(verify_flag));
		end
		setc(9'h000, 8'h00, 1'b1);
		do_cmd(8'h90, 0, 1);
		do_cmd(8'h83, 0, 1);
		do_cmd(8'hc7, 0, 1);
		end_of_test();
	end

	// about 37 commands of some 865 cycles each; allow nearly twice that
	initial begin
		repeat (60000) @(posedge core_clk);
		err_total++;
		end_of_test();
	end
endmodule

`default_nettype wire
